// *** hdl/wdt_pkg.sv ***
// constants, types and operation summary of the fail-safe watchdog timer
// Operation
// - every reset brings the watchdog up enabled and counting without any software action.
// - a disable instruction is accepted at any moment, an enable whenever no disable comes in the same cycle; they stop or resume supervision.
// - an unserviced overflow first raises a prewarning interrupt and afterwards a reset request.
// - the counter is 16 bits wide and advances on system clock ticks divided by 16384 or 256.
// - the counter is loaded from a software-programmed reload value to vary the interval.
// - each service reloads the counter from the reload value and clears the prescaler.
// - after power-up the default reload and prescaler give about 6.5 ms at a 10 MHz clock.
package wdt_pkg;

  // counter and prescaler geometry
  localparam int CNT_WIDTH    = 16;
  localparam int RELOAD_WIDTH = 8;
  localparam int PRE_WIDTH    = 14;
  localparam int LOW_WIDTH    = CNT_WIDTH - RELOAD_WIDTH;

  // prescaler terminal counts, divide by 16384 and by 256
  localparam logic [PRE_WIDTH-1:0] PRE_TERM_SLOW = 14'h3fff;
  localparam logic [PRE_WIDTH-1:0] PRE_TERM_FAST = 14'h00ff;
  localparam logic [PRE_WIDTH-1:0] PRE_ZERO      = 14'h0000;

  // prescaler select encoding
  localparam logic SEL_FAST = 1'b0;
  localparam logic SEL_SLOW = 1'b1;

  // power-up defaults: reload ff00 with /256 gives 65536 clocks, 6.55 ms at 10 MHz
  localparam logic [RELOAD_WIDTH-1:0] DEFAULT_RELOAD = 8'hff;
  localparam logic                    DEFAULT_SEL    = SEL_FAST;
  localparam logic [LOW_WIDTH-1:0]    RELOAD_LOW     = 8'h00;
  localparam logic [CNT_WIDTH-1:0]    CNT_ALL_ONES   = 16'hffff;
  localparam logic [CNT_WIDTH-1:0]    CNT_ONE        = 16'h0001;

  // timing: system clock period and prewarning-to-reset spacing
  localparam int CLK_PERIOD_NS    = 50;
  localparam int PREWARN_TIME_NS  = 1000;
  localparam int PREWARN_CYCLES   = (PREWARN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREWARN_CW       = 8;

  // supervision state after an overflow
  typedef enum logic [1:0] {
    st_count,
    st_prewarn,
    st_reset
  } wdt_state_t;

endpackage

// *** hdl/wdt_prescaler.sv ***
// selectable system clock prescaler producing one-cycle counter ticks
`timescale 1ns/1ps
module wdt_prescaler (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  input  wire logic clear,
  input  wire logic slow_select,
  // tick out
  output logic      tick
);

  logic [wdt_pkg::PRE_WIDTH-1:0] count;
  logic [wdt_pkg::PRE_WIDTH-1:0] next_count;
  logic [wdt_pkg::PRE_WIDTH-1:0] terminal;

  // terminal count picks /16384 or /256
  always_comb begin
    terminal = (slow_select == wdt_pkg::SEL_SLOW) ? wdt_pkg::PRE_TERM_SLOW
                                                  : wdt_pkg::PRE_TERM_FAST;
    tick     = run && !clear && (count >= terminal);
  end

  // clear wins over counting so a service restarts a whole prescaler period
  always_comb begin
    if (clear) begin
      next_count = wdt_pkg::PRE_ZERO;
    end else if (!run) begin
      next_count = count;
    end else if (count >= terminal) begin
      next_count = wdt_pkg::PRE_ZERO; // switching select downward still wraps at once
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= wdt_pkg::PRE_ZERO;
    end else begin
      count <= next_count;
    end
  end

endmodule

// *** hdl/fail_safe_watchdog_timer.sv ***
// fail-safe watchdog timer: 16-bit counter, prewarning and reset request
`timescale 1ns/1ps
module fail_safe_watchdog_timer #(
  parameter int PREWARN_CYCLES = wdt_pkg::PREWARN_CYCLES
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // instruction strobes from the core, one cycle each
  input  wire logic                           service_instruction,
  input  wire logic                           watchdog_disable_instruction,
  input  wire logic                           watchdog_enable_instruction,
  // configuration from the core
  input  wire logic [wdt_pkg::RELOAD_WIDTH-1:0] watchdog_reload_value,
  input  wire logic                           slow_select,
  // events to the system
  output logic                                prewarn_irq,
  output logic                                reset_request,
  // status
  output logic                                enabled,
  output logic                                prewarn_pending,
  output logic [wdt_pkg::CNT_WIDTH-1:0]       count,
  output logic [wdt_pkg::CNT_WIDTH-1:0]       service_margin
);

  // full 16-bit reload image built from the programmed high byte
  function automatic logic [wdt_pkg::CNT_WIDTH-1:0] reload_image(
    input logic [wdt_pkg::RELOAD_WIDTH-1:0] hi
  );
    reload_image = {hi, wdt_pkg::RELOAD_LOW};
  endfunction

  // configuration latches
  logic [wdt_pkg::RELOAD_WIDTH-1:0] reload;
  logic [wdt_pkg::RELOAD_WIDTH-1:0] next_reload;
  logic                             sel;
  logic                             next_sel;

  // reload and select are taken on every service, so a new interval
  // only starts at a service point, never in the middle of one
  always_comb begin
    next_reload = reload;
    next_sel    = sel;
    if (service_instruction) begin
      next_reload = watchdog_reload_value;
      next_sel    = slow_select;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload <= wdt_pkg::DEFAULT_RELOAD;
      sel    <= wdt_pkg::DEFAULT_SEL;
    end else begin
      reload <= next_reload;
      sel    <= next_sel;
    end
  end

  // enable flag
  logic next_enabled;

  // disable wins if both strobes arrive together: the safer reading is
  // impossible, so the last explicit intent of software is honoured
  always_comb begin
    next_enabled = enabled;
    if (watchdog_enable_instruction) begin
      next_enabled = 1'b1;
    end
    if (watchdog_disable_instruction) begin
      next_enabled = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enabled <= 1'b1;
    end else begin
      enabled <= next_enabled;
    end
  end

  // prescaler
  logic run;
  logic tick;

  // supervision stops the prescaler as well, so re-enabling continues
  // the interrupted interval instead of starting a fresh one; the price
  // is that a long disable does not shorten the next interval
  assign run = enabled;

  // a service clears the prescaler on the same edge that reloads the counter;
  // the select it sees is the latched one, so a new select only counts from
  // the service edge on, when the cleared prescaler starts its first period
  wdt_prescaler wdt_prescaler_inst (
    .clk         (clk),
    .rst         (rst),
    .run         (run),
    .clear       (service_instruction),
    .slow_select (sel),
    .tick        (tick)
  );

  // watchdog counter
  // power-up count and margin follow from the default reload value
  localparam logic [wdt_pkg::CNT_WIDTH-1:0] POWER_UP_COUNT  =
    {wdt_pkg::DEFAULT_RELOAD, wdt_pkg::RELOAD_LOW};
  localparam logic [wdt_pkg::CNT_WIDTH-1:0] POWER_UP_MARGIN =
    wdt_pkg::CNT_ALL_ONES - POWER_UP_COUNT;

  logic [wdt_pkg::CNT_WIDTH-1:0] next_count;
  logic [wdt_pkg::CNT_WIDTH-1:0] next_service_margin;
  logic                          at_top;
  logic                          overflow;

  // overflow is the tick that would carry out of the all-ones value; the
  // counter then restarts from the latched reload value, so the interval
  // after a prewarning is as long as the one that ran out
  always_comb begin
    at_top   = (count == wdt_pkg::CNT_ALL_ONES);
    overflow = tick && at_top;
  end

  // a service takes the reload value straight from the core, so the
  // counter and the reload latch agree from the service edge onwards;
  // the prescaler never ticks in a service cycle, so the two cannot race
  always_comb begin
    next_count = count;
    if (service_instruction) begin
      next_count = reload_image(watchdog_reload_value);
    end else if (overflow) begin
      next_count = reload_image(reload);
    end else if (tick) begin
      next_count = count + wdt_pkg::CNT_ONE;
    end
    next_service_margin = wdt_pkg::CNT_ALL_ONES - next_count;
  end

  // counter and margin registers; the margin is registered from the next
  // count so it needs no subtractor behind the output pins
  always_ff @(posedge clk) begin
    if (rst) begin
      count          <= POWER_UP_COUNT;
      service_margin <= POWER_UP_MARGIN;
    end else begin
      count          <= next_count;
      service_margin <= next_service_margin;
    end
  end

  // supervision sequence after an overflow
  // once the prewarning is out a service no longer stops the reset request:
  // a program that let the counter run out is not trusted to have recovered
  // prewarning and reset request stand PREWARN_CYCLES edges apart
  localparam int                 WARN_CW   = wdt_pkg::PREWARN_CW;
  localparam logic [WARN_CW-1:0] WARN_LAST = WARN_CW'(PREWARN_CYCLES - 1);
  localparam logic [WARN_CW-1:0] WARN_ZERO = {WARN_CW{1'b0}};

  wdt_pkg::wdt_state_t state;
  wdt_pkg::wdt_state_t next_state;
  logic [WARN_CW-1:0]  warn_count;
  logic [WARN_CW-1:0]  next_warn_count;
  logic                next_prewarn_irq;
  logic                next_reset_request;
  logic                next_prewarn_pending;

  // the prewarning lasts one cycle and gives software a short head start
  // before the reset request; the delay only runs while supervision is
  // on, so a disable in that window also holds the reset back
  always_comb begin
    next_state         = state;
    next_warn_count    = warn_count;
    next_prewarn_irq   = 1'b0;
    next_reset_request = reset_request;
    unique case (state)
      wdt_pkg::st_count: begin
        if (overflow) begin
          next_state       = wdt_pkg::st_prewarn;
          next_warn_count  = WARN_ZERO;
          next_prewarn_irq = 1'b1;
        end
      end
      wdt_pkg::st_prewarn: begin
        if (!enabled) begin
          next_warn_count = warn_count;
        end else if (warn_count == WARN_LAST) begin
          next_state         = wdt_pkg::st_reset;
          next_reset_request = 1'b1;
        end else begin
          next_warn_count = warn_count + 1'b1;
        end
      end
      wdt_pkg::st_reset: begin
        // held until the system resets the block
        next_reset_request = 1'b1;
      end
      default: begin
        next_state         = wdt_pkg::st_reset; // a corrupted code fails safe
        next_reset_request = 1'b1;
      end
    endcase
    next_prewarn_pending = (next_state == wdt_pkg::st_prewarn);
  end

  // supervision registers; the prewarning pulse and the status bit come
  // straight from flip-flops so the interrupt logic sees a clean edge
  always_ff @(posedge clk) begin
    if (rst) begin
      state           <= wdt_pkg::st_count;
      warn_count      <= WARN_ZERO;
      prewarn_irq     <= 1'b0;
      reset_request   <= 1'b0;
      prewarn_pending <= 1'b0;
    end else begin
      state           <= next_state;
      warn_count      <= next_warn_count;
      prewarn_irq     <= next_prewarn_irq;
      reset_request   <= next_reset_request;
      prewarn_pending <= next_prewarn_pending;
    end
  end

endmodule

// *** verif/wdt_asserts.sv ***
// port checker for the watchdog
`timescale 1ns/1ps
module wdt_asserts #(parameter int PREWARN_CYCLES = 4) (
  input wire logic clk, rst, service_instruction, slow_select,
  input wire logic watchdog_disable_instruction, watchdog_enable_instruction,
  input wire logic [wdt_pkg::RELOAD_WIDTH-1:0] watchdog_reload_value,
  input wire logic prewarn_irq, reset_request, enabled, prewarn_pending,
  input wire logic [wdt_pkg::CNT_WIDTH-1:0] count, service_margin);
  localparam int GAP = PREWARN_CYCLES + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic warned, next_warned;
  // remembers a prewarning until the next reset
  always_comb next_warned = rst ? 1'b0 : (warned | prewarn_irq);
  always_ff @(posedge clk) warned <= next_warned;
  a_reset_arms: assert property ($fell(rst) |-> enabled) else $error("not armed");
  a_disable_stops: assert property (watchdog_disable_instruction |=> !enabled) else $error("dis");
  a_warn_first: assert property ($rose(reset_request) |-> warned) else $error("order");
  a_warn_gap: assert property ($rose(prewarn_irq) |-> ##[1:GAP] reset_request) else $error("gap");
  a_warn_pending: assert property ($rose(prewarn_irq) |-> prewarn_pending) else $error("pend");
  a_quiet_off: assert property (!enabled |=> !$rose(prewarn_irq) && !$rose(reset_request))
    else $error("quiet");
  a_hold_off: assert property (!enabled && !service_instruction && !watchdog_enable_instruction
    |=> $stable(count)) else $error("hold");
  a_service_load: assert property (service_instruction && enabled |-> ##[1:2]
    count == {watchdog_reload_value, wdt_pkg::RELOAD_LOW}) else $error("reload");
  a_count_step: assert property (enabled && $changed(count) && !$past(service_instruction)
    && $past(count) != wdt_pkg::CNT_ALL_ONES |-> count == $past(count) + wdt_pkg::CNT_ONE)
    else $error("step");
endmodule
bind fail_safe_watchdog_timer wdt_asserts #(.PREWARN_CYCLES(PREWARN_CYCLES))
  wdt_asserts_inst (
  .clk(clk), .rst(rst), .service_instruction(service_instruction), .slow_select(slow_select),
  .watchdog_disable_instruction(watchdog_disable_instruction),
  .watchdog_enable_instruction(watchdog_enable_instruction),
  .watchdog_reload_value(watchdog_reload_value), .prewarn_irq(prewarn_irq),
  .reset_request(reset_request), .enabled(enabled), .prewarn_pending(prewarn_pending),
  .count(count), .service_margin(service_margin));

// *** verif/wdt_core_model.sv ***
// core model issuing one-cycle watchdog instructions
`timescale 1ns/1ps
module wdt_core_model (
  input  wire logic clk,
  output logic      srv, dis, ena);
  initial {srv, dis, ena} = 3'h0;
  // op 0 service, 1 disable, 2 enable; launched off the sampling edge
  task automatic issue(input int op);
    @(negedge clk);
    srv = (op == 0);
    dis = (op == 1);
    ena = (op == 2);
    @(negedge clk);
    {srv, dis, ena} = 3'h0;
  endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench for the watchdog
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0, srv, dis, ena, irq, rreq, en, pend;
  logic [7:0]  reload = 8'hff;
  logic [15:0] count, c, margin;
  int failures = 0, total_checks = 0, n;
  always #25 clk = ~clk;
  wdt_core_model wdt_core_model_inst (.clk(clk), .srv(srv), .dis(dis), .ena(ena));
  fail_safe_watchdog_timer #(.PREWARN_CYCLES(4)) fail_safe_watchdog_timer_inst (.clk(clk),
    .rst(rst), .service_instruction(srv), .watchdog_disable_instruction(dis),
    .watchdog_enable_instruction(ena), .watchdog_reload_value(reload), .slow_select(slow),
    .prewarn_irq(irq), .reset_request(rreq), .enabled(en), .prewarn_pending(pend),
    .count(count), .service_margin(margin));
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int k); repeat (k) @(negedge clk); endtask
  task automatic svc(); wdt_core_model_inst.issue(0); endtask
  // armed at power-up, one tick per 256 clocks
  task automatic t_power_up();
    check("enabled", {15'h0, en}, 16'h1);
    check("count", count, 16'hff00);
    check("margin", margin, 16'h00ff);
    cyc(300);
    check("tick", count, 16'hff01);
  endtask
  // a late service must clear the prescaler, else the tick comes early
  task automatic t_service();
    cyc(200);
    reload = 8'hf0;
    svc();
    check("reload", count, 16'hf000);
    cyc(250);
    check("cleared", count, 16'hf000);
    cyc(10);
    check("fast", count, 16'hf001);
    slow = 1'b1;
    svc();
    cyc(600);
    check("slow", count, 16'hf000);
  endtask
  // disable freezes the count, enable resumes
  task automatic t_disable();
    slow = 1'b0;
    svc();
    wdt_core_model_inst.issue(1);
    c = count;
    check("off", {15'h0, en}, 16'h0);
    cyc(600);
    check("held", count, c);
    wdt_core_model_inst.issue(2);
    check("on", {15'h0, en}, 16'h1);
  endtask
  // unserviced overflow: prewarning after 65536 clocks, then reset request
  task automatic t_overflow();
    reload = 8'hff;
    svc();
    for (n = 0; irq !== 1'b1 && n < 70000; n++) cyc(1);
    if (n == 70000) failures++;
    else begin
      check("warn time", {15'h0, n == 65536}, 16'h1);
      check("pending", {15'h0, pend}, 16'h1);
      check("no reset yet", {15'h0, rreq}, 16'h0);
      for (n = 0; rreq !== 1'b1 && n < 10; n++) cyc(1);
      check("reset req", {15'h0, rreq}, 16'h1);
    end
  endtask
  initial begin
    cyc(20);
    rst = 1'b0;
    t_power_up();
    t_service();
    t_disable();
    t_overflow();
    wrap_up();
  end
endmodule
